// >>> epd_div.sv
`default_nettype none
// ========================================
// Enable pulse divider, one pulse every (div_m1+1) cycles while run is high
module epd_div (
    input wire logic core_clk, // Core clock
    input wire logic srst, // Synchronous reset
    input wire logic run, // Count enable
    input wire logic [5:0] div_m1, // Period minus one
    output logic tick // One-cycle enable
);
    logic [5:0] cnt_reg;
    wire logic wrap = (cnt_reg >= div_m1);
    always_ff @(posedge core_clk)
    begin
        if (srst || !run)
        begin
            cnt_reg <= 6'h00;
            tick <= 1'b0;
        end
        else
        begin
            cnt_reg <= wrap ? 6'h00 : 6'(cnt_reg + 6'h01);
            tick <= wrap;
        end
    end
endmodule
`default_nettype wire

// >>> epd_periph_model.sv
`default_nettype none
// ========================================
// Plug-in board: four windows of sixteen byte registers
module epd_periph_model (
    input wire logic core_clk, // Core clock
    input wire logic [3:0] sel_n, // Chip selects, active low
    input wire logic rd_strobe_n, // Read strobe
    input wire logic wr_strobe_n, // Write strobe
    input wire logic [3:0] addr, // Port address
    input wire logic [7:0] bus_in, // Resolved data bus
    input wire logic [3:0] delay_cyc, // Read access delay
    output logic drv_en, // Board drives the bus
    output logic [7:0] drv_data // Board data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [4][16];
    int w;
    int rd_age;
    initial
    begin
        for (int i = 0; i < 64; i++)
        begin
            mem[i / 16][i % 16] = 8'(i * 37 + 5);
        end
        rd_age = 0;
    end
    always_comb
    begin
        w = 4;
        for (int i = 0; i < 4; i++)
        begin
            if (sel_n[i] == 1'b0)
            begin
                w = i;
            end
        end
    end
    // drive only while selected and read strobe low
    always @(posedge core_clk)
    begin
        rd_age <= (w < 4 && !rd_strobe_n) ? rd_age + 1 : 0;
        if (w < 4 && !wr_strobe_n)
        begin
            mem[w][addr] <= bus_in;
        end
    end
    assign drv_en = (w < 4) && !rd_strobe_n && (rd_age >= 32'(delay_cyc));
    assign drv_data = (w < 4) ? mem[w][addr] : 8'h00;
endmodule
`default_nettype wire

// >>> epd_pkg.sv
`default_nettype none
package epd_pkg;
    // ========================================
    // Address map, 20-bit bus addresses
    localparam int ADDR_W = 20;
    localparam logic [19:0] PSEL0_BASE = 20'h7e000;
    localparam logic [19:0] PSEL0_LAST = 20'h7e7ff;
    localparam logic [19:0] PSEL1_BASE = 20'h7e800;
    localparam logic [19:0] PSEL1_LAST = 20'h7efff;
    localparam logic [19:0] PSEL2_BASE = 20'h7f000;
    localparam logic [19:0] PSEL2_LAST = 20'h7f7ff;
    localparam logic [19:0] PSEL3_BASE = 20'h7f800;
    localparam logic [19:0] PSEL3_LAST = 20'h7ffff;
    // Boot ROM 00000-07FFF, shadow 08000-0FFFF: A19..A16 == 0 selects it, A15 ignored
    localparam logic [3:0] ROM_PAGE = 4'h0;
    // User RAM 10000-17FFF, shadow 18000-1FFFF: A19..A16 == 1, A15 ignored
    localparam logic [3:0] RAM_PAGE = 4'h1;
    localparam int PAGE_LSB = 16;
    // Port address and data widths
    localparam int PORT_ADDR_W = 4;
    localparam int DATA_W = 8;
    // General I/O bit positions
    localparam int GIO_W = 8;
    localparam logic [7:0] GIO_CAPTURE_MASK = 8'h87;
    localparam logic [7:0] GIO_COMPARE_MASK = 8'h78;
    // Clock synthesis figures
    localparam int REF_HZ = 32768;
    localparam int PLL_MULT = 256;
    localparam int PLL_DOUBLE = 2;
    localparam int BASE_HZ = REF_HZ * PLL_MULT;
    localparam int BUS_HZ = BASE_HZ * PLL_DOUBLE;
    // Core clock rate and bus strobe divider derived from it
    localparam int CORE_HZ = 250000000;
    localparam int BUS_DIV = CORE_HZ / BUS_HZ;
    localparam int BASE_DIV = CORE_HZ / BASE_HZ;
    localparam int DIV_W = 6;
    localparam logic [5:0] BUS_DIV_M1 = 6'(BUS_DIV - 1);
    localparam logic [5:0] BASE_DIV_M1 = 6'(BASE_DIV - 1);
    // Pin synchroniser depth
    localparam int SYNC_STAGES = 3;
endpackage
`default_nettype wire

// >>> epd_sync.sv
`default_nettype none
// ========================================
// Three-stage pin synchroniser, change accepted when stages two and three agree
module epd_sync (
    input wire logic core_clk, // Core clock
    input wire logic srst, // Synchronous reset
    input wire logic pin_in, // Asynchronous pin
    output logic level_out // Filtered level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_out <= 1'b0;
        end
        else
        begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg)
                level_out <= s3_reg;
        end
    end
endmodule
`default_nettype wire

// >>> epd_top.sv
// Summary of operation
// - Port is memory mapped with separate read and write strobes.
// - Drive four low address bits and eight buffered data bits, bit 0 LSB.
// - Select 0 asserts only for addresses PERIPH_SELECT_0 through 7E7FF.
// - Select 1 asserts only for addresses PERIPH_SELECT_1 through 7EFFF.
// - Select 2 asserts only for addresses PERIPH_SELECT_2 through 7F7FF.
// - Select 3 asserts only for addresses PERIPH_SELECT_3 through 7FFFF.
// - Decoder also drives boot ROM and user RAM enables directly.
// - ROM and RAM respond also at their shadow ranges.
// - Eight-bit I/O port: bits 0-2,7 capture inputs, bits 3-6 compare outputs.
// - Synthesizer multiplies the 32.768 kHz reference by 256 initially.
// - After reset, no access runs until the loop reports lock.
// - After lock, firmware doubles the clock; port runs at 16.78 MHz.
`default_nettype none
module epd_top (
    input wire logic core_clk, // 250 MHz core clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic pll_lock, // Synthesizer lock pin, asynchronous
    input wire logic clk_double, // Firmware clock-double control bit
    input wire logic req_valid, // Bus access request
    input wire logic req_write, // 1 write, 0 read
    input wire logic [19:0] req_addr, // Bus address
    input wire logic [7:0] req_wdata, // Write data
    output logic req_ready, // Request taken
    output logic rsp_valid, // Access finished
    output logic [7:0] rsp_rdata, // Read data from port
    output logic run_enable, // Instruction execution allowed
    output logic bus_tick, // Bus-rate enable pulse
    output logic rd_strobe_n, // Port read strobe
    output logic wr_strobe_n, // Port write strobe
    output logic periph_select_0_n, // Chip select PERIPH_SELECT_0 window
    output logic periph_select_1_n, // Chip select PERIPH_SELECT_1 window
    output logic periph_select_2_n, // Chip select PERIPH_SELECT_2 window
    output logic periph_select_3_n, // Chip select PERIPH_SELECT_3 window
    output logic rom_en_n, // Boot ROM enable
    output logic ram_rd_en_n, // User RAM read enable
    output logic ram_wr_en_n, // User RAM write enable
    output logic port_addr_bit0, // Port address bit 0
    output logic port_addr_bit1, // Port address bit 1
    output logic port_addr_bit2, // Port address bit 2
    output logic port_addr_bit3, // Port address bit 3
    input wire logic buffered_data_lsb_in, // Data bit 0 pin in
    input wire logic [6:0] buffered_data_upper_in, // Data bits 7..1 pin in
    output logic buffered_data_lsb_out, // Data bit 0 out
    output logic [6:0] buffered_data_upper_out, // Data bits 7..1 out
    output logic data_oe, // Data bus drive enable
    input wire logic capture_in_a, // I/O bit 0
    input wire logic capture_in_b, // I/O bit 1
    input wire logic capture_in_c, // I/O bit 2
    input wire logic capture_in_d, // I/O bit 7
    output logic [3:0] capture_level, // Synced capture inputs d,c,b,a
    input wire logic [3:0] compare_set, // Compare output values d..a
    output logic compare_out_a, // I/O bit 3
    output logic compare_out_b, // I/O bit 4
    output logic compare_out_c, // I/O bit 5
    output logic compare_out_d // I/O bit 6
);
    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} epd_state_e;

    // ========================================
    // Lock and clock rate
    logic lock_s;
    logic rate_tick;
    logic [5:0] rate_div;
    logic [7:0] data_in_s;
    logic [3:0] cap_s;
    epd_sync u_sync_lock (
        .core_clk(core_clk),
        .srst(srst),
        .pin_in(pll_lock),
        .level_out(lock_s)
    );
    assign rate_div = clk_double ? epd_pkg::BUS_DIV_M1 : epd_pkg::BASE_DIV_M1;
    epd_div u_div (
        .core_clk(core_clk),
        .srst(srst),
        .run(lock_s),
        .div_m1(rate_div),
        .tick(rate_tick)
    );

    // ========================================
    // Pin inputs
    wire logic [7:0] data_pins = {buffered_data_upper_in, buffered_data_lsb_in};
    genvar gi;
    generate
        for (gi = 0; gi < epd_pkg::DATA_W; gi++)
        begin : g_din
            epd_sync u_sd (
                .core_clk(core_clk),
                .srst(srst),
                .pin_in(data_pins[gi]),
                .level_out(data_in_s[gi])
            );
        end
    endgenerate
    wire logic [3:0] cap_pins = {capture_in_d, capture_in_c, capture_in_b, capture_in_a};
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_cap
            epd_sync u_sc (
                .core_clk(core_clk),
                .srst(srst),
                .pin_in(cap_pins[gi]),
                .level_out(cap_s[gi])
            );
        end
    endgenerate

    // ========================================
    // Address decode
    // windows 0 to 3
    wire logic hit0 = (req_addr >= epd_pkg::PSEL0_BASE) && (req_addr <= epd_pkg::PSEL0_LAST);
    wire logic hit1 = (req_addr >= epd_pkg::PSEL1_BASE) && (req_addr <= epd_pkg::PSEL1_LAST);
    wire logic hit2 = (req_addr >= epd_pkg::PSEL2_BASE) && (req_addr <= epd_pkg::PSEL2_LAST);
    wire logic hit3 = (req_addr >= epd_pkg::PSEL3_BASE) && (req_addr <= epd_pkg::PSEL3_LAST);
    // memory pages, bit 15 ignored so shadows alias
    wire logic [3:0] page = req_addr[19:epd_pkg::PAGE_LSB];
    wire logic hit_rom = (page == epd_pkg::ROM_PAGE) && !req_write;
    wire logic hit_ram = (page == epd_pkg::RAM_PAGE);
    wire logic [3:0] hit_port = {hit3, hit2, hit1, hit0};

    // ========================================
    // Access sequencer
    epd_state_e st_reg, st_next;
    logic [3:0] sel_reg;
    logic wr_reg;
    logic mem_rom_reg;
    logic mem_ram_reg;
    wire logic take = (st_reg == ST_IDLE) && req_valid && rate_tick;
    wire logic any_hit = (|hit_port) || hit_rom || hit_ram;

    always_comb
    begin
        st_next = st_reg;
        unique case (st_reg)
            ST_IDLE: if (take) st_next = ST_SETUP;
            ST_SETUP: if (rate_tick) st_next = ST_STROBE;
            ST_STROBE: if (rate_tick) st_next = ST_HOLD;
            ST_HOLD: if (rate_tick) st_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (srst || !lock_s)
            st_reg <= ST_IDLE;
        else
            st_reg <= st_next;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            sel_reg <= 4'h0;
            wr_reg <= 1'b0;
            mem_rom_reg <= 1'b0;
            mem_ram_reg <= 1'b0;
        end
        else if (take)
        begin
            sel_reg <= hit_port;
            wr_reg <= req_write;
            mem_rom_reg <= hit_rom;
            mem_ram_reg <= hit_ram;
        end
    end

    // ========================================
    // Registered pin outputs
    wire logic active = (st_next == ST_SETUP) || (st_next == ST_STROBE) || (st_next == ST_HOLD);
    wire logic strobe_nx = (st_next == ST_STROBE);
    wire logic [3:0] sel_nx = take ? hit_port : sel_reg;
    wire logic wr_nx = take ? req_write : wr_reg;
    wire logic rom_nx = take ? hit_rom : mem_rom_reg;
    wire logic ram_nx = take ? hit_ram : mem_ram_reg;
    wire logic lock_ok = lock_s && !srst;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            periph_select_0_n <= 1'b1;
            periph_select_1_n <= 1'b1;
            periph_select_2_n <= 1'b1;
            periph_select_3_n <= 1'b1;
            rd_strobe_n <= 1'b1;
            wr_strobe_n <= 1'b1;
            rom_en_n <= 1'b1;
            ram_rd_en_n <= 1'b1;
            ram_wr_en_n <= 1'b1;
            data_oe <= 1'b0;
        end
        else
        begin
            periph_select_0_n <= !(lock_ok && active && sel_nx[0]);
            periph_select_1_n <= !(lock_ok && active && sel_nx[1]);
            periph_select_2_n <= !(lock_ok && active && sel_nx[2]);
            periph_select_3_n <= !(lock_ok && active && sel_nx[3]);
            rd_strobe_n <= !(lock_ok && strobe_nx && !wr_nx && (|sel_nx));
            wr_strobe_n <= !(lock_ok && strobe_nx && wr_nx && (|sel_nx));
            rom_en_n <= !(lock_ok && strobe_nx && rom_nx);
            ram_rd_en_n <= !(lock_ok && strobe_nx && ram_nx && !wr_nx);
            ram_wr_en_n <= !(lock_ok && strobe_nx && ram_nx && wr_nx);
            // device drives only for port writes
            data_oe <= lock_ok && active && wr_nx && (|sel_nx);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            {port_addr_bit3, port_addr_bit2, port_addr_bit1, port_addr_bit0} <= 4'h0;
            {buffered_data_upper_out, buffered_data_lsb_out} <= 8'h00;
        end
        else if (take)
        begin
            {port_addr_bit3, port_addr_bit2, port_addr_bit1, port_addr_bit0} <= req_addr[3:0];
            {buffered_data_upper_out, buffered_data_lsb_out} <= req_wdata;
        end
    end

    // ========================================
    // Handshake, read capture, status
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
            run_enable <= 1'b0;
            bus_tick <= 1'b0;
            capture_level <= 4'h0;
        end
        else
        begin
            req_ready <= take;
            rsp_valid <= (st_reg == ST_HOLD) && rate_tick && lock_s;
            if ((st_reg == ST_STROBE) && rate_tick && !wr_reg && (|sel_reg))
                rsp_rdata <= data_in_s;
            else if (take && !any_hit)
                rsp_rdata <= 8'h00;
            run_enable <= lock_s;
            bus_tick <= rate_tick;
            capture_level <= cap_s;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            {compare_out_d, compare_out_c, compare_out_b, compare_out_a} <= 4'h0;
        else
            {compare_out_d, compare_out_c, compare_out_b, compare_out_a} <= compare_set;
    end

    // ========================================
    // Checks
    wire logic [3:0] sels_n = {periph_select_3_n, periph_select_2_n, periph_select_1_n, periph_select_0_n};
    property p_one_sel;
        @(posedge core_clk) disable iff (srst) $countones(~sels_n) <= 1;
    endproperty
    a_one_sel: assert property (p_one_sel) else $error("two selects low");
    property p_sel0_range;
        @(posedge core_clk) disable iff (srst) take && hit0 |=> !periph_select_0_n && periph_select_1_n;
    endproperty
    a_sel0_range: assert property (p_sel0_range) else $error("select 0 missed");
    property p_sel1_range;
        @(posedge core_clk) disable iff (srst) take && hit1 |=> !periph_select_1_n && periph_select_0_n;
    endproperty
    a_sel1_range: assert property (p_sel1_range) else $error("select 1 missed");
    property p_sel2_range;
        @(posedge core_clk) disable iff (srst) take && hit2 |=> !periph_select_2_n && periph_select_3_n;
    endproperty
    a_sel2_range: assert property (p_sel2_range) else $error("select 2 missed");
    property p_sel3_range;
        @(posedge core_clk) disable iff (srst) take && hit3 |=> !periph_select_3_n && periph_select_2_n;
    endproperty
    a_sel3_range: assert property (p_sel3_range) else $error("select 3 missed");
    property p_strobes_apart;
        @(posedge core_clk) disable iff (srst) !(!rd_strobe_n && !wr_strobe_n);
    endproperty
    a_strobes_apart: assert property (p_strobes_apart) else $error("both strobes low");
    property p_strobe_in_sel;
        @(posedge core_clk) disable iff (srst) !rd_strobe_n || !wr_strobe_n |-> sels_n != 4'hf;
    endproperty
    a_strobe_in_sel: assert property (p_strobe_in_sel) else $error("strobe without select");
    property p_no_run_unlocked;
        @(posedge core_clk) disable iff (srst) !lock_s |=> sels_n == 4'hf && rom_en_n && !req_ready;
    endproperty
    a_no_run_unlocked: assert property (p_no_run_unlocked) else $error("access before lock");
    property p_rom_shadow;
        @(posedge core_clk) disable iff (srst) take && hit_rom |-> ##[1:200] !rom_en_n;
    endproperty
    a_rom_shadow: assert property (p_rom_shadow) else $error("rom enable missed");
endmodule
`default_nettype wire

// >>> test_epd_top.sv
`default_nettype none
`define EPD_CHK(got, exp) check_val(32'(got), 32'(exp))
module test_epd_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, srst = 1'b1, pll_lock = 1'b0, clk_double = 1'b0;
    logic req_valid = 1'b0, req_write = 1'b0;
    logic [19:0] req_addr = 20'h00000;
    logic [7:0] req_wdata = 8'h00;
    logic [3:0] caps = 4'h0, compare_set = 4'h0, delay_cyc = 4'h0;
    logic req_ready, rsp_valid, run_enable, bus_tick, rd_strobe_n, wr_strobe_n, data_oe;
    logic [3:0] sel_n, capture_level, pa, pa_seen;
    logic rom_en_n, ram_rd_en_n, ram_wr_en_n, lsb_out, drv_en, cmp_a, cmp_b, cmp_c, cmp_d;
    logic [6:0] upper_out;
    logic [7:0] rsp_rdata, drv_data, bus_wire, idle_pat = 8'h00, wd_seen;
    logic [8:0] seen = 9'h000;
    int mismatches = 0, check_count = 0, cycles = 0, slen = 0, gap = 0, last_gap = 0;
    logic [15:0] lfsr = 16'h0047;
    logic [19:0] edge_addr [8] = '{20'h7e000, 20'h7e7ff, 20'h7e800, 20'h7efff, 20'h7f000, 20'h7f7ff, 20'h7f800,
        20'h7ffff};
    logic [7:0] ref_mem [4][16];
    always #2 core_clk = ~core_clk;
    epd_top epd_top_inst (.core_clk(core_clk), .srst(srst), .pll_lock(pll_lock), .clk_double(clk_double),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .run_enable(run_enable),
        .bus_tick(bus_tick), .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n),
        .periph_select_0_n(sel_n[0]), .periph_select_1_n(sel_n[1]), .periph_select_2_n(sel_n[2]),
        .periph_select_3_n(sel_n[3]), .rom_en_n(rom_en_n), .ram_rd_en_n(ram_rd_en_n), .ram_wr_en_n(ram_wr_en_n),
        .port_addr_bit0(pa[0]), .port_addr_bit1(pa[1]), .port_addr_bit2(pa[2]), .port_addr_bit3(pa[3]),
        .buffered_data_lsb_in(bus_wire[0]), .buffered_data_upper_in(bus_wire[7:1]),
        .buffered_data_lsb_out(lsb_out), .buffered_data_upper_out(upper_out), .data_oe(data_oe),
        .capture_in_a(caps[0]), .capture_in_b(caps[1]), .capture_in_c(caps[2]), .capture_in_d(caps[3]),
        .capture_level(capture_level), .compare_set(compare_set), .compare_out_a(cmp_a),
        .compare_out_b(cmp_b), .compare_out_c(cmp_c), .compare_out_d(cmp_d));
    epd_periph_model epd_periph_model_inst (.core_clk(core_clk), .sel_n(sel_n), .rd_strobe_n(rd_strobe_n),
        .wr_strobe_n(wr_strobe_n), .addr(pa), .bus_in(bus_wire), .delay_cyc(delay_cyc), .drv_en(drv_en),
        .drv_data(drv_data));
    // Undriven bus shows a pattern that changes every cycle
    assign bus_wire = data_oe ? {upper_out, lsb_out} : (drv_en ? drv_data : idle_pat);
    always @(posedge core_clk)
    begin
        idle_pat <= ~bus_wire;
        cycles <= cycles + 1;
    end
    // ========================================
    // Access monitor, restarted by each request acceptance
    always @(negedge core_clk)
    begin
        seen <= (req_ready ? 9'h000 : seen) | ~{rom_en_n, ram_rd_en_n, ram_wr_en_n, rd_strobe_n, wr_strobe_n, sel_n};
        slen <= (req_ready ? 0 : slen) + int'(!rd_strobe_n || !wr_strobe_n);
        if (!wr_strobe_n)
        begin
            wd_seen <= bus_wire;
        end
        if (sel_n != 4'hf)
        begin
            pa_seen <= pa;
        end
        gap <= bus_tick ? 1 : gap + 1;
        if (bus_tick)
        begin
            last_gap <= gap;
        end
        `EPD_CHK(data_oe && drv_en, 1'b0);
    end
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic access(input logic wr, input logic [19:0] a, input logic [7:0] d);
        int n;
        int w;
        logic [3:0] pg;
        @(negedge core_clk);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        n = 0;
        while (req_ready !== 1'b1 && n < 400)
        begin
            @(negedge core_clk);
            n++;
        end
        `EPD_CHK(req_ready, 1'b1);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 400)
        begin
            @(negedge core_clk);
            n++;
        end
        w = (a >= 20'h7e000) ? int'((a - 20'h7e000) >> 11) : 4;
        pg = a[19:16];
        `EPD_CHK(rsp_valid, 1'b1);
        `EPD_CHK(last_gap, clk_double ? epd_pkg::BUS_DIV : epd_pkg::BASE_DIV);
        `EPD_CHK(seen[3:0], (w < 4) ? (4'h1 << w) : 4'h0);
        `EPD_CHK(seen[8:6], {!wr && pg == 4'h0, !wr && pg == 4'h1, wr && pg == 4'h1});
        if (clk_double)
        begin
            `EPD_CHK(n <= 3 * epd_pkg::BUS_DIV + 2, 1'b1);
        end
        if (w < 4)
        begin
            `EPD_CHK(seen[5:4], {!wr, wr});
            `EPD_CHK(pa_seen, a[3:0]);
            `EPD_CHK(clk_double ? slen : (slen > epd_pkg::BUS_DIV), clk_double ? epd_pkg::BUS_DIV : 1);
            if (wr)
            begin
                ref_mem[w][a[3:0]] = d;
                `EPD_CHK(wd_seen, d);
            end
            else
            begin
                `EPD_CHK(rsp_rdata, ref_mem[w][a[3:0]]);
            end
        end
        else if (!wr && pg > 4'h1)
        begin
            `EPD_CHK(rsp_rdata, 8'h00);
        end
    endtask
    initial
    begin
        for (int i = 0; i < 64; i++)
        begin
            ref_mem[i / 16][i % 16] = 8'(i * 37 + 5);
        end
        repeat (8) @(negedge core_clk);
        `EPD_CHK({sel_n, rd_strobe_n, wr_strobe_n, rom_en_n, ram_rd_en_n, ram_wr_en_n, data_oe}, 10'h3fe);
        srst = 1'b0;
        req_valid = 1'b1;
        req_addr = 20'h7e000;
        repeat (60) @(negedge core_clk);
        `EPD_CHK({run_enable, seen[3:0], req_ready}, 6'h00);
        req_valid = 1'b0;
        pll_lock = 1'b1;
        repeat (8) @(negedge core_clk);
        `EPD_CHK(run_enable, 1'b1);
        // base-rate and doubled-rate accesses on every window edge
        for (int i = 0; i < 2; i++)
        begin
            clk_double = 1'(i);
            for (int k = 0; k < 8; k++)
            begin
                access(1'b0, edge_addr[k], 8'h00);
            end
            access(1'b1, 20'h7e7ff, 8'ha5);
            access(1'b0, 20'h7e7ff, 8'h00);
            access(1'b0, 20'h7e800, 8'h00);
            access(1'b1, 20'h7f7ff, 8'h3c);
            access(1'b0, 20'h7f800, 8'h00);
            access(1'b0, 20'h7ffff, 8'h00);
            access(1'b0, 20'h7dfff, 8'h00);
            access(1'b0, 20'h00000, 8'h00);
            access(1'b0, 20'h08000, 8'h00);
            access(1'b1, 20'h0ffff, 8'h11);
            access(1'b0, 20'h1ffff, 8'h00);
            access(1'b1, 20'h18000, 8'h22);
            access(1'b0, 20'h20000, 8'h00);
        end
        // slow board answers within the strobe
        delay_cyc = 4'h3;
        for (int i = 0; i < 40; i++)
        begin
            lfsr = next_rand(lfsr);
            access(lfsr[15], {7'h3f, lfsr[12:0]}, lfsr[7:0] ^ 8'h96);
        end
        for (int i = 0; i < 8; i++)
        begin
            lfsr = next_rand(lfsr);
            caps = lfsr[3:0];
            compare_set = lfsr[7:4];
            repeat (6) @(negedge core_clk);
            `EPD_CHK(capture_level, lfsr[3:0]);
            `EPD_CHK({cmp_d, cmp_c, cmp_b, cmp_a}, lfsr[7:4]);
        end
        complete_run();
    end
    always @(posedge core_clk)
    begin
        if (cycles == 60000)
        begin
            mismatches++;
            complete_run();
        end
    end
endmodule
`default_nettype wire
